/* File: hdl/imrs_cfg.svh */
// constants for the two-wire master read sequencer
// assumes a 250 MHz core clock; included by bare name
`ifndef IMRS_CFG_SVH
`define IMRS_CFG_SVH

// core clock period in ns
`define IMRS_CLK_NS      4
// least half period of the bus clock in ns
`define IMRS_HALF_NS     5000
// half period in core cycles, rounded up
`define IMRS_HALF_CYC    ((`IMRS_HALF_NS + `IMRS_CLK_NS - 1) / `IMRS_CLK_NS)
// width of the phase timer
`define IMRS_TMR_W       12
// receive buffer shape
`define IMRS_FIFO_DEPTH  32
`define IMRS_DATA_W      8
// bit index of the read/write flag in the address byte
`define IMRS_RW_BIT      0
// index of the last bit of a byte
`define IMRS_LAST_BIT    3'h7

`endif

/* File: hdl/imrs_fifo.sv */
// receive buffer: synchronous fifo with registered read data
// assumes one clock, synchronous active-low reset
`timescale 1ns/1ps
module imrs_fifo
    import imrs_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic [WIDTH-1:0]      outData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [AW:0]           count
);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic [WIDTH-1:0] outData_q, outData_d;
    logic             push, pop;

    // ------------------------------------------------------------
    // pointer and count update
    // ------------------------------------------------------------
    always_comb begin
        push     = inValid && inReady;
        pop      = outValid && outReady;
        wrPtr_d  = push ? AW'(wrPtr_q + 1'b1) : wrPtr_q;
        rdPtr_d  = pop ? AW'(rdPtr_q + 1'b1) : rdPtr_q;
        cnt_d    = (AW+1)'(cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
        // bypass when the word lands on the next head slot
        if (push && wrPtr_q == rdPtr_d) begin
            outData_d = inData;
        end else begin
            outData_d = mem[rdPtr_d];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wrPtr_q   <= '0;
            rdPtr_q   <= '0;
            cnt_q     <= '0;
            outData_q <= '0;
        end else begin
            wrPtr_q   <= wrPtr_d;
            rdPtr_q   <= rdPtr_d;
            cnt_q     <= cnt_d;
            outData_q <= outData_d;
        end
    end

    // storage write
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    assign inReady  = (cnt_q != (AW+1)'(DEPTH));
    assign outValid = (cnt_q != '0);
    assign outData  = outData_q;
    assign count    = cnt_q;

endmodule

/* File: hdl/imrs_pkg.sv */
// types shared by the read sequencer files
// assumes nothing of its surroundings
package imrs_pkg;

    // sequencer states
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_START,
        ST_BIT_LO,
        ST_BIT_HI,
        ST_ACK_LO,
        ST_ACK_HI,
        ST_HOLD,
        ST_RS_LO,
        ST_RS_HI,
        ST_STOP_LO,
        ST_STOP_HI
    } imrs_state_e;

    typedef logic [7:0] imrs_byte_t;

endpackage

/* File: hdl/imrs_seq.sv */
// two-wire bus master read, acknowledge, repeated start and stop sequencer
// assumes open-drain pins resolved outside; control bits are plain ports
`timescale 1ns/1ps
`include "imrs_cfg.svh"

module imrs_seq
    import imrs_pkg::*;
#(
    parameter int HALF_CYC   = `IMRS_HALF_CYC,
    parameter int FIFO_DEPTH = `IMRS_FIFO_DEPTH
) (
    input  wire logic   core_clk,
    input  wire logic   rst_n,
    input  wire logic   xferSet,
    input  wire logic   ctlStart,
    input  wire logic   ctlStop,
    input  wire logic   ctlAckNack,
    input  wire logic   ctlMasterAbort,
    input  wire logic   rxFullIe,
    input  imrs_byte_t  txData,
    input  wire logic   bufRead,
    output imrs_byte_t  dataBuf,
    output logic        bufValid,
    output logic        xferByte,
    output logic        rxFull,
    output logic        ackStatus,
    output logic        unitBusy,
    output logic        masterRx,
    output logic        rxFullIrq,
    input  wire logic   sclIn,
    output logic        sclOut,
    output logic        sclOe_n,
    input  wire logic   sdaIn,
    output logic        sdaOut,
    output logic        sdaOe_n
);

    localparam int AW = $clog2(FIFO_DEPTH);

    imrs_state_e      state_q, state_d;
    logic [`IMRS_TMR_W-1:0] tmr_q, tmr_d;
    logic [2:0]       bitCnt_q, bitCnt_d;
    imrs_byte_t       shift_q, shift_d;
    logic             isAddr_q, isAddr_d;
    logic             nackSel_q, nackSel_d;
    logic             stopReq_q, stopReq_d;
    logic             xfer_q, xfer_d;
    logic             rxFull_q, rxFull_d;
    logic             ackSt_q, ackSt_d;
    logic             busy_q, busy_d;
    logic             mRx_q, mRx_d;
    logic             sclRel_q, sclRel_d;
    logic             sdaRel_q, sdaRel_d;
    logic             sclMeta_q, sclSync_q, sdaMeta_q, sdaSync_q;
    logic             phaseEnd, push, fifoReady;
    logic [AW:0]      fifoCount;
    logic             addrRw_q, addrRw_d, txAddrBit;
    imrs_byte_t       addrByte_q, addrByte_d;

    // true for states other than idle where the master releases the clock line
    function automatic logic highPhase(input imrs_state_e s);
        return (s == ST_START) || (s == ST_BIT_HI) || (s == ST_ACK_HI) ||
               (s == ST_RS_HI) || (s == ST_STOP_HI);
    endfunction

    // true when an address byte asked for a read
    function automatic logic isAddrRead(input logic addr, input logic rw);
        return addr && rw;
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sclMeta_q <= 1'b1;
            sclSync_q <= 1'b1;
            sdaMeta_q <= 1'b1;
            sdaSync_q <= 1'b1;
        end else begin
            sclMeta_q <= sclIn;
            sclSync_q <= sclMeta_q;
            sdaMeta_q <= sdaIn;
            sdaSync_q <= sdaMeta_q;
        end
    end

    // phase ends after a half period; high phases wait for a stretched clock
    assign phaseEnd = (tmr_q == `IMRS_TMR_W'(HALF_CYC - 1)) && (!highPhase(state_q) || sclSync_q);

    // ------------------------------------------------------------
    // sequencer next state
    // ------------------------------------------------------------
    always_comb begin
        state_d   = state_q;
        tmr_d     = phaseEnd ? '0 : (tmr_q == `IMRS_TMR_W'(HALF_CYC - 1)) ? tmr_q : `IMRS_TMR_W'(tmr_q + 1'b1);
        bitCnt_d  = bitCnt_q;
        shift_d   = shift_q;
        isAddr_d  = isAddr_q;
        nackSel_d = nackSel_q;
        stopReq_d = stopReq_q;
        xfer_d    = xfer_q;
        ackSt_d   = ackSt_q;
        busy_d    = busy_q;
        mRx_d     = mRx_q;
        push      = 1'b0;
        case (state_q)
            ST_IDLE: begin
                tmr_d  = '0;
                busy_d = 1'b0;
                if (xferSet && ctlStart) begin
                    // clear receive mode, send the address as transmitter
                    state_d   = ST_START;
                    shift_d   = txData;
                    isAddr_d  = 1'b1;
                    mRx_d     = 1'b0;
                    stopReq_d = ctlStop;
                    xfer_d    = 1'b1;
                    busy_d    = 1'b1;
                end
            end
            ST_START: begin
                if (phaseEnd) begin
                    state_d  = ST_BIT_LO;
                    bitCnt_d = '0;
                end
            end
            ST_BIT_LO: begin
                if (phaseEnd) begin
                    state_d = ST_BIT_HI;
                end
            end
            ST_BIT_HI: begin
                if (phaseEnd) begin
                    // receiver samples data, transmitter moves to the next bit
                    shift_d = {shift_q[6:0], mRx_q ? sdaSync_q : 1'b0};
                    if (bitCnt_q == `IMRS_LAST_BIT) begin
                        state_d = ST_ACK_LO;
                    end else begin
                        state_d  = ST_BIT_LO;
                        bitCnt_d = 3'(bitCnt_q + 1'b1);
                    end
                end
            end
            ST_ACK_LO: begin
                if (phaseEnd) begin
                    state_d = ST_ACK_HI;
                end
            end
            ST_ACK_HI: begin
                if (phaseEnd && mRx_q && fifoReady) begin
                    // byte enters the buffer only after the ack bit time
                    push    = 1'b1;
                    xfer_d  = 1'b0;
                    ackSt_d = nackSel_q;
                    state_d = stopReq_q ? ST_STOP_LO : ST_HOLD;
                end else if (phaseEnd && !mRx_q) begin
                    ackSt_d = sdaSync_q;
                    xfer_d  = 1'b0;
                    if (isAddr_q) begin
                        // direction bit picks the mode right after the ack
                        mRx_d   = isAddrRead(isAddr_q, addrRw_q);
                        state_d = ST_HOLD;
                    end else begin
                        state_d = stopReq_q ? ST_STOP_LO : ST_HOLD;
                    end
                    isAddr_d = 1'b0;
                end else if (phaseEnd) begin
                    tmr_d = tmr_q; // buffer full: hold the clock until room
                end
            end
            ST_HOLD: begin
                tmr_d = '0;
                if (xferSet && ctlStart) begin
                    // chained transaction: repeated start instead of stop
                    state_d   = ST_RS_LO;
                    shift_d   = txData;
                    isAddr_d  = 1'b1;
                    mRx_d     = 1'b0;
                    stopReq_d = ctlStop;
                    xfer_d    = 1'b1;
                end else if (xferSet) begin
                    state_d   = ST_BIT_LO;
                    bitCnt_d  = '0;
                    shift_d   = mRx_q ? 8'hFF : txData;
                    nackSel_d = ctlAckNack;
                    stopReq_d = ctlStop;
                    xfer_d    = 1'b1;
                end else if (ctlMasterAbort && !xfer_q) begin
                    state_d = ST_STOP_LO;
                end
            end
            ST_RS_LO: begin
                if (phaseEnd) begin
                    state_d = ST_RS_HI;
                end
            end
            ST_RS_HI: begin
                if (phaseEnd) begin
                    state_d = ST_START;
                end
            end
            ST_STOP_LO: begin
                if (phaseEnd) begin
                    state_d = ST_STOP_HI;
                end
            end
            ST_STOP_HI: begin
                if (phaseEnd) begin
                    state_d = ST_IDLE;
                    mRx_d   = 1'b0;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // direction bit of the last address byte
    assign addrByte_d = ((state_q == ST_IDLE || state_q == ST_HOLD) && xferSet && ctlStart) ? txData : addrByte_q;
    assign txAddrBit  = addrByte_q[`IMRS_RW_BIT];
    assign addrRw_d   = (isAddr_q && state_q == ST_BIT_LO && bitCnt_q == 3'h0) ? txAddrBit : addrRw_q;

    // ------------------------------------------------------------
    // pin drive: release is high, drive low is enable low
    // ------------------------------------------------------------
    always_comb begin
        sclRel_d = highPhase(state_d) || state_d == ST_IDLE;
        // data trails the clock by one cycle, so it never moves on a clock edge
        case (state_q)
            ST_IDLE:    sdaRel_d = 1'b1;
            ST_START:   sdaRel_d = 1'b0;
            ST_BIT_LO,
            ST_BIT_HI:  sdaRel_d = mRx_q ? 1'b1 : shift_q[7];
            // transmitter releases, receiver drives the programmed answer
            ST_ACK_LO,
            ST_ACK_HI:  sdaRel_d = mRx_q ? nackSel_q : 1'b1;
            ST_HOLD:    sdaRel_d = 1'b1;
            ST_RS_LO,
            ST_RS_HI:   sdaRel_d = 1'b1;
            ST_STOP_LO,
            ST_STOP_HI: sdaRel_d = 1'b0;
            default:    sdaRel_d = 1'b1;
        endcase
    end

    // receive-full: set on push wins over a draining read
    always_comb begin
        rxFull_d = push || (rxFull_q && !(bufRead && bufValid && fifoCount == (AW+1)'(1)));
    end

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_q    <= ST_IDLE;
            tmr_q      <= '0;
            bitCnt_q   <= '0;
            shift_q    <= '0;
            isAddr_q   <= 1'b0;
            nackSel_q  <= 1'b0;
            stopReq_q  <= 1'b0;
            xfer_q     <= 1'b0;
            rxFull_q   <= 1'b0;
            ackSt_q    <= 1'b0;
            busy_q     <= 1'b0;
            mRx_q      <= 1'b0;
            sclRel_q   <= 1'b1;
            sdaRel_q   <= 1'b1;
            addrRw_q   <= 1'b0;
            addrByte_q <= '0;
        end else begin
            state_q    <= state_d;
            tmr_q      <= tmr_d;
            bitCnt_q   <= bitCnt_d;
            shift_q    <= shift_d;
            isAddr_q   <= isAddr_d;
            nackSel_q  <= nackSel_d;
            stopReq_q  <= stopReq_d;
            xfer_q     <= xfer_d;
            rxFull_q   <= rxFull_d;
            ackSt_q    <= ackSt_d;
            busy_q     <= busy_d;
            mRx_q      <= mRx_d;
            sclRel_q   <= sclRel_d;
            sdaRel_q   <= sdaRel_d;
            addrRw_q   <= addrRw_d;
            addrByte_q <= addrByte_d;
        end
    end

    // ------------------------------------------------------------
    // receive buffer
    // ------------------------------------------------------------
    imrs_fifo #(
        .WIDTH (`IMRS_DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .inData   (shift_q),
        .inValid  (push),
        .inReady  (fifoReady),
        .outData  (dataBuf),
        .outValid (bufValid),
        .outReady (bufRead),
        .count    (fifoCount)
    );

    // status outputs
    assign xferByte  = xfer_q;
    assign rxFull    = rxFull_q;
    assign ackStatus = ackSt_q;
    assign unitBusy  = busy_q;
    assign masterRx  = mRx_q;
    assign rxFullIrq = rxFull_q && !xfer_q && rxFullIe;
    assign sclOut    = 1'b0;
    assign sdaOut    = 1'b0;
    assign sclOe_n   = sclRel_q;
    assign sdaOe_n   = sdaRel_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence ackPhase;
        state_q == ST_ACK_LO || state_q == ST_ACK_HI;
    endsequence

    sequence holdRestart;
        state_q == ST_HOLD && xferSet && ctlStart;
    endsequence

    ack_release_a: assert property ((state_q == ST_ACK_HI && !mRx_q) |-> sdaOe_n)
        else $error("ack phase of transmitter does not release data");
    ack_drive_a: assert property ((state_q == ST_ACK_HI && mRx_q) |-> sdaOe_n == nackSel_q)
        else $error("receiver ack drive differs from programmed answer");
    push_after_ack_a: assert property (push |-> state_q == ST_ACK_HI && $past(state_q) == ST_ACK_HI)
        else $error("byte buffered outside the ack bit time");
    push_flags_a: assert property (push |=> !xferByte && rxFull)
        else $error("buffering did not clear transfer and set full");
    irq_gate_a: assert property ((rxFull && !xferByte && rxFullIe) |-> rxFullIrq)
        else $error("receive-full irq missing");
    rx_mode_a: assert property ($rose(masterRx) |-> $past(state_q) == ST_ACK_HI && addrRw_q)
        else $error("receiver mode entered without read address ack");
    nack_stop_a: assert property ((push && stopReq_q) |=> state_q == ST_STOP_LO && unitBusy)
        else $error("final byte with stop does not start stop while busy");
    abort_stop_a: assert property ((state_q == ST_HOLD && !xferSet && ctlMasterAbort && !xferByte)
        |=> state_q == ST_STOP_LO)
        else $error("abort did not lead to stop");
    restart_a: assert property (holdRestart |=> state_q == ST_RS_LO ##1 sdaOe_n)
        else $error("chained start did not produce repeated start");
    start_tx_a: assert property ((state_q == ST_IDLE && xferSet && ctlStart) |=> state_q == ST_START && !masterRx)
        else $error("read did not begin as transmitter");
    ack_hold_a: assert property (ackPhase |-> !sclOe_n || state_q == ST_ACK_HI)
        else $error("clock not driven in ack low phase");

endmodule

/* File: verif/imrs_seq_tb.sv */
// self-checking bench for the master read sequencer with one slave model
// assumes pull-ups on both lines; bus half period shortened to 4 core cycles
`timescale 1ns/1ps
module imrs_seq_tb
    import imrs_pkg::*;
;
    localparam logic [6:0] SLV = 7'h2C;

    logic       core_clk       = 1'b0;
    logic       rst_n          = 1'b0;
    logic       xferSet        = 1'b0;
    logic       ctlStart       = 1'b0;
    logic       ctlStop        = 1'b0;
    logic       ctlAckNack     = 1'b0;
    logic       ctlMasterAbort = 1'b0;
    logic       rxFullIe       = 1'b0;
    logic       bufRead        = 1'b0;
    imrs_byte_t txData         = 8'h00;
    imrs_byte_t dataBuf;
    logic       bufValid, xferByte, rxFull, ackStatus, unitBusy, masterRx, rxFullIrq;
    logic       sclOut, sclOe_n, sdaOut, sdaOe_n, sclLine, sdaLine, slvOe_n, lastAck;
    int         startCnt, stopCnt, s, t, k;
    int         failures        = 0;
    int         samples_checked = 0;
    int         cycleCount      = 0;

    // ----------------------------------------
    // clock, wires, instances
    // ----------------------------------------
    always #2 core_clk = ~core_clk;
    assign sclLine = sclOe_n | sclOut;
    assign sdaLine = (sdaOe_n | sdaOut) & slvOe_n;

    imrs_seq #(.HALF_CYC(4), .FIFO_DEPTH(32)) i_dut (
        .core_clk(core_clk), .rst_n(rst_n), .xferSet(xferSet), .ctlStart(ctlStart), .ctlStop(ctlStop),
        .ctlAckNack(ctlAckNack), .ctlMasterAbort(ctlMasterAbort), .rxFullIe(rxFullIe), .txData(txData),
        .bufRead(bufRead), .dataBuf(dataBuf), .bufValid(bufValid), .xferByte(xferByte), .rxFull(rxFull),
        .ackStatus(ackStatus), .unitBusy(unitBusy), .masterRx(masterRx), .rxFullIrq(rxFullIrq),
        .sclIn(sclLine), .sclOut(sclOut), .sclOe_n(sclOe_n), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n));

    imrs_slave_model #(.ADDR(SLV), .FIRST(8'hA0)) u_slave (
        .sclLine(sclLine), .sdaLine(sdaLine), .sdaOe_n(slvOe_n), .lastAck(lastAck),
        .startCnt(startCnt), .stopCnt(stopCnt));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one transfer request with its control levels
    task automatic issue(input logic st, input logic sp, input logic nk, input logic ie, input imrs_byte_t d);
        @(negedge core_clk);
        {ctlStart, ctlStop, ctlAckNack, rxFullIe, txData} = {st, sp, nk, ie, d};
        xferSet = 1'b1;
        @(negedge core_clk);
        xferSet = 1'b0;
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        while (xferByte !== 1'b0 && n < 2000) begin
            @(negedge core_clk);
            n++;
        end
        check("xferByte", 8'h00, {7'h00, xferByte});
    endtask

    // stop seen on the wire, then idle and both pins released
    task automatic wait_stop(input int prev);
        int n;
        n = 0;
        while ((stopCnt == prev || unitBusy !== 1'b0) && n < 400) begin
            @(negedge core_clk);
            n++;
        end
        check("stops", 8'(prev + 1), stopCnt[7:0]);
        check("idle", 8'h03, {5'h00, unitBusy, sclOe_n, sdaOe_n});
    endtask

    task automatic abort_stop();
        int prev;
        prev = stopCnt;
        @(negedge core_clk);
        ctlMasterAbort = 1'b1;
        wait_stop(prev);
        ctlMasterAbort = 1'b0;
    endtask

    task automatic pop(input imrs_byte_t exp);
        int n;
        n = 0;
        while (bufValid !== 1'b1 && n < 400) begin
            @(negedge core_clk);
            n++;
        end
        check("dataBuf", exp, dataBuf);
        bufRead = 1'b1;
        @(negedge core_clk);
        bufRead = 1'b0;
        repeat (2) @(negedge core_clk);
    endtask

    // hang guard
    always @(posedge core_clk) begin
        cycleCount++;
        if (cycleCount == 20000) begin
            failures++;
            finish_test();
        end
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (12) @(negedge core_clk);
        rst_n = 1'b1;
        check("reset", 8'h03, {xferByte, rxFull, ackStatus, unitBusy, masterRx, rxFullIrq, sclOe_n, sdaOe_n});
        // long read: fill the buffer until a byte is held, then drain
        issue(1'b1, 1'b0, 1'b0, 1'b1, {SLV, 1'b1});
        repeat (4) @(negedge core_clk);
        check("busy", 8'h01, {7'h00, unitBusy});
        wait_done();
        check("rxmode", 8'h02, {6'h00, masterRx, ackStatus});
        for (k = 0; k < 32; k++) begin
            issue(1'b0, 1'b0, 1'b0, 1'b1, 8'h00);
            wait_done();
            check("rxdone", 8'h0A, {4'h0, rxFull, xferByte, rxFullIrq, ackStatus});
            check("ackSent", 8'h00, {7'h00, lastAck});
        end
        s = stopCnt;
        issue(1'b0, 1'b1, 1'b1, 1'b1, 8'h00);
        repeat (200) @(negedge core_clk);
        check("held", 8'h01, {7'h00, xferByte});
        pop(8'hA0);
        wait_done();
        check("lastByte", 8'h07, {5'h00, ackStatus, unitBusy, lastAck});
        for (k = 1; k < 32; k++) pop(8'hA0 + 8'(k));
        pop(8'hC0);
        wait_stop(s);
        check("drained", 8'h00, {6'h00, bufValid, rxFull});
        // chaining through a repeated start, then abort
        s = stopCnt;
        issue(1'b1, 1'b0, 1'b0, 1'b0, {SLV, 1'b1});
        wait_done();
        issue(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
        wait_done();
        check("nackNoIrq", 8'h05, {5'h00, rxFull, rxFullIrq, ackStatus});
        pop(8'hC1);
        t = startCnt;
        issue(1'b1, 1'b0, 1'b1, 1'b0, {SLV, 1'b1});
        wait_done();
        check("restart", 8'h10, {4'(startCnt - t), 4'(stopCnt - s)});
        issue(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
        wait_done();
        pop(8'hC2);
        abort_stop();
        // write direction keeps transmitter mode; unknown address gets no ack
        issue(1'b1, 1'b0, 1'b0, 1'b0, {SLV, 1'b0});
        wait_done();
        check("txmode", 8'h00, {6'h00, masterRx, ackStatus});
        abort_stop();
        issue(1'b1, 1'b0, 1'b0, 1'b0, {7'h13, 1'b1});
        wait_done();
        check("noAck", 8'h01, {7'h00, ackStatus});
        abort_stop();
        finish_test();
    end
endmodule

/* File: verif/imrs_slave_model.sv */
// behavioural slave on the two-wire bus: acks its address, sends a counting byte stream
// assumes open-drain lines resolved by the bench with pull-ups; drives the data line low only
`timescale 1ns/1ps
module imrs_slave_model #(
    parameter logic [6:0] ADDR  = 7'h2C,
    parameter logic [7:0] FIRST = 8'hA0
) (
    input  wire logic sclLine,
    input  wire logic sdaLine,
    output logic      sdaOe_n,
    output logic      lastAck,
    output int        startCnt,
    output int        stopCnt
);
    logic       active  = 1'b0;
    logic       inAddr  = 1'b0;
    logic       rdMode  = 1'b0;
    logic       matched = 1'b0;
    logic [3:0] bitCnt  = 4'h0;
    logic [7:0] shiftIn = 8'h00;
    logic [7:0] txByte  = FIRST;

    initial begin
        sdaOe_n  = 1'b1;
        lastAck  = 1'b1;
        startCnt = 0;
        stopCnt  = 0;
    end

    // ----------------------------------------
    // framing: data moving while clock is high
    // ----------------------------------------
    always @(negedge sdaLine) if (sclLine === 1'b1) begin
        startCnt++;
        active = 1'b1;
        inAddr = 1'b1;
        rdMode = 1'b0;
        bitCnt = 4'h0;
    end
    always @(posedge sdaLine) if (sclLine === 1'b1) begin
        stopCnt++;
        active = 1'b0;
    end

    // ----------------------------------------
    // sampling on the rising clock
    // ----------------------------------------
    always @(posedge sclLine) if (active) begin
        if (bitCnt < 4'h8) shiftIn = {shiftIn[6:0], sdaLine};
        else if (rdMode) begin
            lastAck = sdaLine;
            txByte++;
            if (sdaLine) active = 1'b0; // nack ends the stream
        end
        if (inAddr && bitCnt == 4'h7) matched = (shiftIn[7:1] == ADDR);
        if (inAddr && bitCnt == 4'h8) begin
            inAddr = 1'b0;
            rdMode = shiftIn[0];
            if (!matched) active = 1'b0;
        end
        bitCnt = (bitCnt == 4'h8) ? 4'h0 : bitCnt + 4'h1;
    end

    // drive while the clock is low, a little after its fall
    always @(negedge sclLine) begin
        #6;
        if (!active) sdaOe_n = 1'b1;
        else if (inAddr) sdaOe_n = !(bitCnt == 4'h8 && matched);
        else if (rdMode && bitCnt < 4'h8) sdaOe_n = txByte[3'h7 - bitCnt[2:0]];
        else sdaOe_n = 1'b1; // released during the master's ack
    end
endmodule
